// ==== verilog/kil_regs.vh ====
`ifndef KIL_REGS_VH
`define KIL_REGS_VH

// register byte offsets on the apb slave
`define KIL_STATUS_CONTROL_OFF 12'h000
`define KIL_PIN_ENABLE_OFF     12'h004
`define KIL_PORT_DIR_OFF       12'h008
`define KIL_PORT_DATA_OFF      12'h00c
`define KIL_PORT_PIN_OFF       12'h010

// status/control field positions
`define KIL_MODE_BIT    0
`define KIL_MASK_BIT    1
`define KIL_ACK_BIT     2
`define KIL_PENDING_BIT 3

// reset values
`define KIL_PIN_ENABLE_RST 5'h00
`define KIL_PORT_DIR_RST   5'h00
`define KIL_PORT_DATA_RST  5'h00

// number of keypad pins
`define KIL_NUM_PINS 5

`endif

// ==== verilog/kil_sync.v ====
`timescale 1ns/1ps
`default_nettype none

// two-flop synchroniser for a vector of pin levels
module kil_sync #(
    parameter WIDTH = 5
) (
    input  wire             pclk,
    input  wire             presetn,
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta_ff;
    reg [WIDTH-1:0] sync_ff;

    // reset high: idle keypad pins are pulled up, so no false edge at release
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_ff <= {WIDTH{1'b1}};
            sync_ff <= {WIDTH{1'b1}};
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;

endmodule // kil_sync

`default_nettype wire

// ==== verilog/kil_keypad_interrupt_latch.v ====
// Chosen here: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "kil_regs.vh"

module kil_keypad_interrupt_latch #(
    parameter NPINS = `KIL_NUM_PINS
) (
    input  wire             pclk,
    input  wire             presetn,
    input  wire             psel,
    input  wire             penable,
    input  wire             pwrite,
    input  wire [11:0]      paddr,
    input  wire [31:0]      pwdata,
    output reg  [31:0]      prdata,
    output wire             pready,
    output wire             pslverr,
    input  wire [NPINS-1:0] pin_in,
    output wire [NPINS-1:0] pin_out,
    output wire [NPINS-1:0] pin_oe,
    output wire [NPINS-1:0] pin_pullup_en,
    input  wire             vector_fetch,
    output wire             irq_request,
    output wire             wake_request
);

    reg  [NPINS-1:0] pin_source_enables_ff;
    reg  [NPINS-1:0] port_a_direction_ff;
    reg  [NPINS-1:0] port_data_ff;
    reg              trigger_sense_select_ff;
    reg              request_mask_ff;
    reg              latch_ff;
    reg              all_high_ff;
    reg              nxt_latch;
    reg              ack_pend_ff;
    reg              nxt_ack_pend;
    wire             sel_status;
    wire             sel_enable;
    wire             sel_dir;
    wire             sel_data;
    wire             sel_pins;
    wire             sel_any;
    wire             ack_write;
    wire [NPINS-1:0] port_level;
    wire [NPINS-1:0] pin_sync;
    wire             any_low;
    wire             fall_event;
    wire             ack_pulse;
    wire             wr_en;
    wire             rd_en;
    wire             pending_flag;

    // one-cycle access phase, no wait states
    assign pready  = 1'b1;
    assign wr_en   = psel & penable & pwrite;
    assign rd_en   = psel & penable & ~pwrite;

    function addr_hit;
        input [11:0] addr;
        input [11:0] off;
        begin
            addr_hit = (addr[11:2] == off[11:2]);
        end
    endfunction

    // one decode per register, shared by writes, reads and the error answer
    assign sel_status = addr_hit(paddr, `KIL_STATUS_CONTROL_OFF);
    assign sel_enable = addr_hit(paddr, `KIL_PIN_ENABLE_OFF);
    assign sel_dir    = addr_hit(paddr, `KIL_PORT_DIR_OFF);
    assign sel_data   = addr_hit(paddr, `KIL_PORT_DATA_OFF);
    assign sel_pins   = addr_hit(paddr, `KIL_PORT_PIN_OFF);
    assign sel_any    = sel_status | sel_enable | sel_dir | sel_data |
                        sel_pins;

    // unmapped addresses answer with an error; nothing is written there
    assign pslverr = psel & penable & ~sel_any;

    // pins are sampled twice before any gate sees them
    kil_sync #(
        .WIDTH    (NPINS)
    ) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (pin_in),
        .sync_out (pin_sync)
    );

    // excluded pins count as high
    assign any_low = |(~pin_sync & pin_source_enables_ff);

    // a fall only counts when every enabled pin was high before
    assign fall_event = any_low & all_high_ff;

    // software strobe: a one written to the ack bit of the status word;
    // the bit has no storage, so it can never be seen set afterwards
    assign ack_write = wr_en & sel_status & pwdata[`KIL_ACK_BIT];

    // vector fetch and software strobe share one acknowledge
    assign ack_pulse = vector_fetch | ack_write;

    // enabled pins are inputs with pull-ups; direction bit ignored
    assign pin_oe        = port_a_direction_ff & ~pin_source_enables_ff;
    assign pin_out       = port_data_ff;
    assign pin_pullup_en = pin_source_enables_ff;

    // previous all-high state tracks enable changes as well
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            all_high_ff <= 1'b1;
        end else begin
            all_high_ff <= ~any_low;
        end
    end

    // request latch and the level-mode acknowledge memory.
    // level mode needs an ack and all enabled pins high, in either order,
    // so an ack seen while a pin is still low is kept in ack_pend_ff
    // until the pins return high.
    // a new fall wins over an ack in the same cycle and also forgets an
    // earlier ack: the new request must be answered on its own.
    always @* begin
        nxt_latch    = latch_ff;
        nxt_ack_pend = ack_pend_ff;
        if (!trigger_sense_select_ff) begin
            // edge mode: ack clears at once, whatever the pin levels
            nxt_ack_pend = 1'b0;
            if (ack_pulse) begin
                nxt_latch = 1'b0;
            end
        end else begin
            if (ack_pulse) begin
                if (any_low) begin
                    // a pin still low keeps the request present
                    nxt_latch    = latch_ff;
                    nxt_ack_pend = latch_ff;
                end else begin
                    nxt_latch    = 1'b0;
                    nxt_ack_pend = 1'b0;
                end
            end else if (ack_pend_ff && !any_low) begin
                // ack came first; all enabled pins are high again
                nxt_latch    = 1'b0;
                nxt_ack_pend = 1'b0;
            end
        end
        if (fall_event) begin
            nxt_latch    = 1'b1;
            nxt_ack_pend = 1'b0;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latch_ff    <= 1'b0;
            ack_pend_ff <= 1'b0;
        end else begin
            latch_ff    <= nxt_latch;
            ack_pend_ff <= nxt_ack_pend;
        end
    end

    // the flag is the latch itself; level-mode holding lives in the latch
    assign pending_flag = latch_ff;
    // mask gates only the request, not the flag
    assign irq_request  = pending_flag & ~request_mask_ff;
    // no clock gating here: unit keeps running in wait and stop
    assign wake_request = irq_request;

    // register writes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trigger_sense_select_ff <= 1'b0;
            request_mask_ff         <= 1'b0;
            pin_source_enables_ff   <= `KIL_PIN_ENABLE_RST;
            port_a_direction_ff     <= `KIL_PORT_DIR_RST;
            port_data_ff            <= `KIL_PORT_DATA_RST;
        end else if (wr_en) begin
            // mode and mask are written together; the ack bit is a strobe
            if (sel_status) begin
                trigger_sense_select_ff <= pwdata[`KIL_MODE_BIT];
                request_mask_ff         <= pwdata[`KIL_MASK_BIT];
            end
            // new enables change any_low at once; a low pin may latch
            if (sel_enable) begin
                pin_source_enables_ff <= pwdata[NPINS-1:0];
            end
            // direction drives only pins without a keypad enable; the read path uses it on every pin
            if (sel_dir) begin
                port_a_direction_ff <= pwdata[NPINS-1:0];
            end
            // output data reaches the pin only where it is driven
            if (sel_data) begin
                port_data_ff <= pwdata[NPINS-1:0];
            end
        end
    end

    // pin level where the direction bit is zero, else the data register;
    // the keypad enable forces input but does not open the read path
    assign port_level = (pin_sync & ~port_a_direction_ff) |
                        (port_data_ff & port_a_direction_ff);

    // read word for the addressed register; unmapped and unused bits read 0
    function [31:0] read_word;
        input             st;
        input             en;
        input             dr;
        input             dt;
        input             pn;
        input             mode;
        input             mask;
        input             pend;
        input [NPINS-1:0] enables;
        input [NPINS-1:0] dir;
        input [NPINS-1:0] level;
        input [NPINS-1:0] pins;
        begin
            read_word = 32'h0000_0000;
            if (st) begin
                read_word[`KIL_MODE_BIT]    = mode;
                read_word[`KIL_MASK_BIT]    = mask;
                read_word[`KIL_ACK_BIT]     = 1'b0;
                read_word[`KIL_PENDING_BIT] = pend;
            end
            if (en) begin
                read_word[NPINS-1:0] = enables;
            end
            if (dr) begin
                read_word[NPINS-1:0] = dir;
            end
            if (dt) begin
                read_word[NPINS-1:0] = level;
            end
            if (pn) begin
                read_word[NPINS-1:0] = pins;
            end
        end
    endfunction

    // read data registered at the setup edge; ack bit always zero
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            // loaded at setup so it stands through the access cycle
            prdata <= read_word(sel_status, sel_enable, sel_dir, sel_data,
                                sel_pins, trigger_sense_select_ff,
                                request_mask_ff, pending_flag,
                                pin_source_enables_ff, port_a_direction_ff,
                                port_level, pin_sync);
        end
    end

    // rd_en kept for readability of the access phase
    wire unused_rd = rd_en;

endmodule // kil_keypad_interrupt_latch

`default_nettype wire

// ==== sim/kil_keypad_props.sv ====
`timescale 1ns/1ps
`default_nettype none
// port checks; sense select and mask are not visible from here
module kil_keypad_props #(parameter NPINS = 5) (
    input wire logic             pclk,
    input wire logic             presetn,
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pwrite,
    input wire logic [11:0]      paddr,
    input wire logic [31:0]      prdata,
    input wire logic [NPINS-1:0] pin_in,
    input wire logic [NPINS-1:0] pin_oe,
    input wire logic [NPINS-1:0] pin_pullup_en,
    input wire logic             vector_fetch,
    input wire logic             irq_request,
    input wire logic             wake_request
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // every enabled pin high, and a status read setup
    wire logic quiet = (pin_in & pin_pullup_en) == pin_pullup_en;
    wire logic rd_sc = psel && !penable && !pwrite && paddr == 12'h000;
    AST_INPUT_ONLY:
    assert property ((pin_oe & pin_pullup_en) == '0)
        else $error("enabled pin driven");
    AST_ACK_READS_ZERO:
    assert property (rd_sc |=> prdata[31:4] == '0 && !prdata[2])
        else $error("status read bad");
    AST_PENDING_SHOWN:
    assert property (rd_sc && irq_request |=> prdata[3])
        else $error("pending flag missing");
    AST_RESET_CLEARS:
    assert property ($rose(presetn) |-> !irq_request && pin_pullup_en == '0)
        else $error("reset left state");
    AST_ACK_CLEARS:
    assert property ((quiet && $stable(pin_pullup_en))[*4] ##0 vector_fetch
        |=> !irq_request) else $error("ack did not clear");
    AST_RISE_CAUSE:
    assert property ($rose(irq_request) && !$past(psel) |->
        !$past(quiet, 2) || !$past(quiet, 3) || !$past(quiet, 4))
        else $error("request without a low pin");
    AST_REQ_HOLDS:
    assert property (irq_request && !psel && !vector_fetch &&
        !$past(quiet, 2) |=> irq_request)
        else $error("request dropped");
    AST_WAKE:
    assert property (wake_request == irq_request) else $error("wake bad");
endmodule // kil_keypad_props
bind kil_keypad_interrupt_latch kil_keypad_props #(.NPINS(NPINS)) chk_u (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pin_in,
    .pin_oe, .pin_pullup_en, .vector_fetch, .irq_request, .wake_request);
`default_nettype wire

// ==== sim/kil_keypad_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// keys pull pins low; an undriven pin without pull-up drifts
module kil_keypad_model #(parameter NPINS = 5) (
    input  wire logic             pclk,
    input  wire logic [NPINS-1:0] key_down,
    input  wire logic [NPINS-1:0] pin_out,
    input  wire logic [NPINS-1:0] pin_oe,
    input  wire logic [NPINS-1:0] pin_pullup_en,
    output var  logic [NPINS-1:0] pin_in
);
    logic [NPINS-1:0] last_ff = '0;
    // floating pins flip each cycle so no stale level passes
    always_comb
        pin_in = (pin_oe & pin_out)
               | (~pin_oe & ~key_down & (pin_pullup_en | ~last_ff));
    always @(posedge pclk)
        last_ff <= pin_in;
endmodule // kil_keypad_model
`default_nettype wire

// ==== sim/tb_keypad_interrupt_latch.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "kil_regs.vh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; \
    $display("unexpected at %0t: got %h", $time, a); end end
module tb_keypad_interrupt_latch;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        vector_fetch = 0, pready, pslverr, irq_request, wake_request;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [4:0]  key_down = '0, pin_in, pin_out, pin_oe, pin_pullup_en;
    int          num_errors = 0, n_tests = 0;
    // 25 MHz bus clock
    always #20 pclk = ~pclk;
    kil_keypad_interrupt_latch dut_u (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pin_in,
        .pin_out, .pin_oe, .pin_pullup_en, .vector_fetch, .irq_request,
        .wake_request);
    kil_keypad_model key_u (.pclk, .key_down, .pin_out, .pin_oe,
        .pin_pullup_en, .pin_in);
    task cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // request held until pready is seen high at an edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task sc(input logic [31:0] d);
        apb(1'b1, `KIL_STATUS_CONTROL_OFF, d);
        cyc(2);
    endtask
    // six cycles cover the two-flop sync and the latch
    task keys(input logic [4:0] k);
        key_down <= k;
        cyc(6);
    endtask
    task ack;
        vector_fetch <= 1'b1;
        @(posedge pclk);
        vector_fetch <= 1'b0;
        cyc(2);
    endtask
    task t_reset;
        apb(1'b0, `KIL_STATUS_CONTROL_OFF, 0);
        `CHK(rd, 32'h0);
        apb(1'b0, `KIL_PIN_ENABLE_OFF, 0);
        `CHK(rd[4:0], `KIL_PIN_ENABLE_RST);
    endtask
    task t_edge;
        sc(32'h2);
        apb(1'b1, `KIL_PIN_ENABLE_OFF, 32'h17);
        cyc(1);
        `CHK(pin_pullup_en, 5'h17);
        sc(32'h6);
        sc(32'h0);
        keys(5'h08);
        `CHK(irq_request, 1'b0);
        keys(5'h01);
        `CHK(irq_request, 1'b1);
        sc(32'h4);
        `CHK(irq_request, 1'b0);
        keys(5'h05);
        `CHK(irq_request, 1'b0);
        keys(5'h00);
        keys(5'h10);
        `CHK(irq_request, 1'b1);
        ack;
        `CHK(irq_request, 1'b0);
        keys(5'h00);
    endtask
    task t_level;
        sc(32'h1);
        keys(5'h02);
        ack;
        `CHK(irq_request, 1'b1);
        keys(5'h00);
        `CHK(irq_request, 1'b0);
        keys(5'h02);
        keys(5'h00);
        ack;
        `CHK(irq_request, 1'b0);
        keys(5'h02);
        presetn <= 1'b0;
        cyc(2);
        presetn <= 1'b1;
        cyc(2);
        `CHK(irq_request, 1'b0);
        apb(1'b0, `KIL_STATUS_CONTROL_OFF, 0);
        `CHK(rd[0], 1'b0);
        keys(5'h00);
    endtask
    task t_mask;
        sc(32'h2);
        apb(1'b1, `KIL_PIN_ENABLE_OFF, 32'h1f);
        sc(32'h6);
        keys(5'h01);
        `CHK(wake_request, 1'b0);
        apb(1'b0, `KIL_STATUS_CONTROL_OFF, 0);
        `CHK(rd[3:0], 4'ha);
        sc(32'h0);
        `CHK(wake_request, 1'b1);
        ack;
        keys(5'h00);
    endtask
    task t_port;
        apb(1'b1, `KIL_PORT_DIR_OFF, 32'h1f);
        apb(1'b1, `KIL_PORT_DATA_OFF, 32'h1f);
        apb(1'b1, `KIL_PIN_ENABLE_OFF, 32'h03);
        cyc(1);
        `CHK(pin_oe, 5'h1c);
        apb(1'b0, `KIL_PORT_DATA_OFF, 0);
        `CHK(rd[4:0], 5'h1f);
        `CHK(irq_request, 1'b0);
        apb(1'b1, `KIL_PORT_DIR_OFF, 0);
        sc(32'h2);
        apb(1'b1, `KIL_PIN_ENABLE_OFF, 32'h1f);
        keys(5'h04);
        apb(1'b0, `KIL_PORT_DATA_OFF, 0);
        `CHK(rd[4:0], 5'h1b);
    endtask
    task end_sim;
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        cyc(10);
        presetn <= 1'b1;
        t_reset;
        t_edge;
        t_level;
        t_mask;
        t_port;
        end_sim;
    end
    // the tests need well under a thousand cycles
    initial begin
        cyc(4000);
        num_errors++;
        end_sim;
    end
endmodule // tb_keypad_interrupt_latch
`default_nettype wire
